/* File: src/dacr_regs.sv */
/*
   Control and status register bank of the high-speed converter: port setup and
   software reset, power-down, clock gating, lock interrupt enables and status,
   full-scale code with sleep, output switching mode and phase alignment status.
   Assumes the serial configuration engine presents byte accesses on sys_clk as
   one-cycle read and write strobes; controller and phase levels are asynchronous.
*/
// How it works
// - Power-down bits 5,4,1,0 turn off drivers, receivers, clock receiver, bias; reset 0.
// - Clock-control bit 3 set stops internal clock distribution; resets to 0.
// - Clock-control bits 1 and 0 run receive and mu clocks; both reset to 1.
// - Six write-only enables let each controller update its matching status bit.
// - A zero enable clears its status bit and holds it cleared.
// - Locked status bits read 1 while locked, 0 after lock is lost.
// - Lost status bits read 1 once the controller has unlocked.
// - Full-scale code is low byte plus two high bits, high resets to 2.
// - Upper full-scale register bit 7 puts the converter output to sleep.
// - Two-bit output mode: 0 baseband, 1 return-to-zero, 2 mix; reset 0.
// - Data-clock status bit 2 shows edge before early-delayed phase-0 sample.
// - Data-clock status bit 0 shows edge before late-delayed phase-0 sample.
// - Sync status bit 5 shows sync edge before phase-90 sampling edge.
// - Sync status bit 4 shows sync edge before phase-0 sampling edge.
module dacr_regs
   import dacr_pkg::*;
#(
   parameter int unsigned N_CTRL = 3
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   input  wire dacr_pkg::dacr_cfg_req_s cfg_req,
   output dacr_pkg::dacr_ctrl_s      ctrl,
   output logic [7:0]                cfg_rdata,
   output logic                      cfg_rvalid,
   input  wire dacr_pkg::dacr_lock_s lock_in,
   input  wire dacr_pkg::dacr_phase_s phase_in
);

   import dacr_pkg::*;

   // ==========================================================================
   // Elaboration checks
   initial begin
      if (N_CTRL != 3) $error("dacr_regs: the status layout serves exactly three controllers");
   end

   // ==========================================================================
   // Helper functions
   // Merge only the writable bits so reserved positions stay zero
   function automatic logic [7:0] merge_bits(input logic [7:0] old_val,
                                              input logic [7:0] new_val,
                                              input logic [7:0] mask);
      merge_bits = (old_val & ~mask) | (new_val & mask);
   endfunction

   function automatic logic hit(input dacr_cfg_req_s req, input logic [7:0] ofs);
      hit = req.wr && (req.addr == ofs);
   endfunction

   // ==========================================================================
   // Register storage
   logic [7:0] port_config_soft_reset;
   logic [7:0] interface_power_down;
   logic [7:0] controller_clock_gate;
   logic [7:0] lock_irq_enable;
   logic [7:0] fullscale_code_low;
   logic [7:0] fullscale_code_high_sleep;
   logic [7:0] output_mode_select;

   // ==========================================================================
   // Write decode
   wire wr_port   = hit(cfg_req, OFS_PORT_CONFIG);
   wire wr_power  = hit(cfg_req, OFS_POWER_DOWN);
   wire wr_clock  = hit(cfg_req, OFS_CLOCK_GATE);
   wire wr_irq_en = hit(cfg_req, OFS_IRQ_ENABLE);
   wire wr_fsc_lo = hit(cfg_req, OFS_FSC_LOW);
   wire wr_fsc_hi = hit(cfg_req, OFS_FSC_HIGH);
   wire wr_mode   = hit(cfg_req, OFS_OUTPUT_MODE);

   // A software reset write restores defaults instead of storing its data
   wire soft_reset = wr_port && cfg_req.wdata[BIT_SOFT_RESET];
   wire bank_init  = !rst_n || soft_reset;

   // Value 3 is not a defined mode, so such a write leaves the mode unchanged
   wire mode_legal = (cfg_req.wdata[1:0] != 2'b11);

   // ==========================================================================
   // Next values of the writable registers
   wire [7:0] next_port_config;
   wire [7:0] next_power_down;
   wire [7:0] next_clock_gate;
   wire [7:0] next_irq_enable;
   wire [7:0] next_fsc_low;
   wire [7:0] next_fsc_high;
   wire [7:0] next_output_mode;

   assign next_port_config = wr_port ?
      merge_bits(port_config_soft_reset, cfg_req.wdata, MSK_PORT_CONFIG) :
      port_config_soft_reset;
   assign next_power_down  = wr_power ?
      merge_bits(interface_power_down, cfg_req.wdata, MSK_POWER_DOWN) :
      interface_power_down;
   assign next_clock_gate  = wr_clock ?
      merge_bits(controller_clock_gate, cfg_req.wdata, MSK_CLOCK_GATE) :
      controller_clock_gate;
   assign next_irq_enable  = wr_irq_en ?
      merge_bits(lock_irq_enable, cfg_req.wdata, MSK_IRQ_ENABLE) :
      lock_irq_enable;
   assign next_fsc_low     = wr_fsc_lo ?
      merge_bits(fullscale_code_low, cfg_req.wdata, MSK_FSC_LOW) :
      fullscale_code_low;
   assign next_fsc_high    = wr_fsc_hi ?
      merge_bits(fullscale_code_high_sleep, cfg_req.wdata, MSK_FSC_HIGH) :
      fullscale_code_high_sleep;
   assign next_output_mode = (wr_mode && mode_legal) ?
      merge_bits(output_mode_select, cfg_req.wdata, MSK_OUTPUT_MODE) :
      output_mode_select;

   // ==========================================================================
   // Register update, shared by hard reset and software reset
   always_ff @(posedge sys_clk) begin
      if (bank_init) begin
         port_config_soft_reset    <= RST_PORT_CONFIG;
         interface_power_down      <= RST_POWER_DOWN;
         controller_clock_gate     <= RST_CLOCK_GATE;
         lock_irq_enable           <= RST_IRQ_ENABLE;
         fullscale_code_low        <= RST_FSC_LOW;
         fullscale_code_high_sleep <= RST_FSC_HIGH;
         output_mode_select        <= RST_OUTPUT_MODE;
      end else begin
         port_config_soft_reset    <= next_port_config;
         interface_power_down      <= next_power_down;
         controller_clock_gate     <= next_clock_gate;
         lock_irq_enable           <= next_irq_enable;
         fullscale_code_low        <= next_fsc_low;
         fullscale_code_high_sleep <= next_fsc_high;
         output_mode_select        <= next_output_mode;
      end
   end

   // ==========================================================================
   // Controller indications crossing into sys_clk
   logic [2:0] lock_sync;
   logic [3:0] phase_sync;

   dacr_sync3 #(
      .WIDTH    (3),
      .INIT     (3'h0)
   ) u_lock_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (lock_in),
      .sync_out (lock_sync)
   );

   // Phase comparator results are levels from the sampling clock domain
   dacr_sync3 #(
      .WIDTH    (4),
      .INIT     (4'h0)
   ) u_phase_sync (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .async_in (phase_in),
      .sync_out (phase_sync)
   );

   // ==========================================================================
   // Lock status, one locked/lost pair per controller
   logic [2:0] locked_flags;
   logic [2:0] lost_flags;

   for (genvar c = 0; c < 3; c++) begin : g_ctrl
      dacr_lock_flag u_flag (
         .sys_clk     (sys_clk),
         .rst_n       (rst_n),
         .soft_clr    (soft_reset),
         .locked      (lock_sync[c]),
         .lock_en     (lock_irq_enable[2*c]),
         .lost_en     (lock_irq_enable[2*c+1]),
         .locked_flag (locked_flags[c]),
         .lost_flag   (lost_flags[c])
      );
   end

   // Interleave into lost/locked pairs matching the enable layout
   wire [7:0] irq_status_view = {2'b00,
                                 lost_flags[2], locked_flags[2],
                                 lost_flags[1], locked_flags[1],
                                 lost_flags[0], locked_flags[0]};

   // ==========================================================================
   // Phase alignment views; positions not listed read zero
   wire [7:0] dclk_phase_view = {5'b00000,
                                 phase_sync[3],
                                 1'b0,
                                 phase_sync[2]};
   wire [7:0] sync_phase_view = {2'b00,
                                 phase_sync[1],
                                 phase_sync[0],
                                 4'b0000};

   // ==========================================================================
   // Read multiplexer; enables are write-only and read back zero
   logic [7:0] read_sel;

   always_comb begin
      case (cfg_req.addr)
         OFS_PORT_CONFIG: read_sel = port_config_soft_reset;
         OFS_POWER_DOWN:  read_sel = interface_power_down;
         OFS_CLOCK_GATE:  read_sel = controller_clock_gate;
         OFS_IRQ_STATUS:  read_sel = irq_status_view;
         OFS_FSC_LOW:     read_sel = fullscale_code_low;
         OFS_FSC_HIGH:    read_sel = fullscale_code_high_sleep;
         OFS_OUTPUT_MODE: read_sel = output_mode_select;
         OFS_DCLK_PHASE:  read_sel = dclk_phase_view;
         OFS_SYNC_PHASE:  read_sel = sync_phase_view;
         default:         read_sel = 8'h00;
      endcase
   end

   // Read data is held until the next read, with a one-cycle valid pulse
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cfg_rdata  <= 8'h00;
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rvalid <= cfg_req.rd;
         if (cfg_req.rd) begin
            cfg_rdata <= read_sel;
         end
      end
   end

   // ==========================================================================
   // Control outputs, registered so analog controls see no decode glitches
   wire [9:0] fsc_code = {fullscale_code_high_sleep[1:0], fullscale_code_low};

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl <= '{sdio_out_dir:           1'b0,
                   lsb_first:              1'b0,
                   diff_driver_off:        1'b0,
                   diff_receiver_off:      1'b0,
                   clock_receiver_off:     1'b0,
                   converter_bias_off:     1'b0,
                   clock_distribution_off: 1'b0,
                   receive_ctrl_clock_on:  1'b1,
                   phase_ctrl_clock_on:    1'b1,
                   converter_sleep:        1'b0,
                   fullscale_code:         {RST_FSC_HIGH[1:0], RST_FSC_LOW},
                   output_switch_mode:     DACR_MODE_BASEBAND};
      end else begin
         ctrl.sdio_out_dir           <= port_config_soft_reset[BIT_SDIO_DIR];
         ctrl.lsb_first              <= port_config_soft_reset[BIT_LSB_FIRST];
         ctrl.diff_driver_off        <= interface_power_down[BIT_DRV_OFF];
         ctrl.diff_receiver_off      <= interface_power_down[BIT_RCV_OFF];
         ctrl.clock_receiver_off     <= interface_power_down[BIT_CLKRX_OFF];
         ctrl.converter_bias_off     <= interface_power_down[BIT_BIAS_OFF];
         ctrl.clock_distribution_off <= controller_clock_gate[BIT_DIST_OFF];
         ctrl.receive_ctrl_clock_on  <= controller_clock_gate[BIT_RCV_CLK_ON];
         ctrl.phase_ctrl_clock_on    <= controller_clock_gate[BIT_PH_CLK_ON];
         ctrl.converter_sleep        <= fullscale_code_high_sleep[BIT_SLEEP];
         ctrl.fullscale_code         <= fsc_code;
         ctrl.output_switch_mode     <= dacr_mode_e'(output_mode_select[1:0]);
      end
   end

endmodule

/* File: src/dacr_pkg.sv */
/*
   Shared constants and types of the converter control and status register bank:
   register offsets, bit positions, reset values, writable masks and the carriers
   for configuration requests, control outputs and controller indications.
   Assumes a byte-wide register port driven by the serial configuration engine.
*/
package dacr_pkg;

   // ==========================================================================
   // Register port geometry
   localparam int unsigned DACR_AW          = 8;
   localparam int unsigned DACR_DW          = 8;
   localparam int unsigned DACR_SYNC_STAGES = 3;

   // ==========================================================================
   // Register offsets
   localparam logic [7:0] OFS_PORT_CONFIG   = 8'h00;
   localparam logic [7:0] OFS_POWER_DOWN    = 8'h01;
   localparam logic [7:0] OFS_CLOCK_GATE    = 8'h02;
   localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h03;
   localparam logic [7:0] OFS_IRQ_STATUS    = 8'h04;
   localparam logic [7:0] OFS_FSC_LOW       = 8'h06;
   localparam logic [7:0] OFS_FSC_HIGH      = 8'h07;
   localparam logic [7:0] OFS_OUTPUT_MODE   = 8'h08;
   localparam logic [7:0] OFS_DCLK_PHASE    = 8'h0c;
   localparam logic [7:0] OFS_SYNC_PHASE    = 8'h0d;

   // ==========================================================================
   // Field positions
   localparam int unsigned BIT_SDIO_DIR     = 7;
   localparam int unsigned BIT_LSB_FIRST    = 6;
   localparam int unsigned BIT_SOFT_RESET   = 5;
   localparam int unsigned BIT_DRV_OFF      = 5;
   localparam int unsigned BIT_RCV_OFF      = 4;
   localparam int unsigned BIT_CLKRX_OFF    = 1;
   localparam int unsigned BIT_BIAS_OFF     = 0;
   localparam int unsigned BIT_DIST_OFF     = 3;
   localparam int unsigned BIT_RCV_CLK_ON   = 1;
   localparam int unsigned BIT_PH_CLK_ON    = 0;
   localparam int unsigned BIT_SYNC_LOST    = 5;
   localparam int unsigned BIT_SYNC_LOCK    = 4;
   localparam int unsigned BIT_PH_LOST      = 3;
   localparam int unsigned BIT_PH_LOCK      = 2;
   localparam int unsigned BIT_RCV_LOST     = 1;
   localparam int unsigned BIT_RCV_LOCK     = 0;
   localparam int unsigned BIT_SLEEP        = 7;
   localparam int unsigned BIT_EARLY_WIN    = 2;
   localparam int unsigned BIT_LATE_WIN     = 0;
   localparam int unsigned BIT_SYNC_QUARTER = 5;
   localparam int unsigned BIT_SYNC_ZERO    = 4;

   // ==========================================================================
   // Values after reset and writable bits
   localparam logic [7:0] RST_PORT_CONFIG   = 8'h00;
   localparam logic [7:0] RST_POWER_DOWN    = 8'h00;
   localparam logic [7:0] RST_CLOCK_GATE    = 8'h03;
   localparam logic [7:0] RST_IRQ_ENABLE    = 8'h00;
   localparam logic [7:0] RST_FSC_LOW       = 8'h00;
   localparam logic [7:0] RST_FSC_HIGH      = 8'h02;
   localparam logic [7:0] RST_OUTPUT_MODE   = 8'h00;
   localparam logic [7:0] MSK_PORT_CONFIG   = 8'hc0;
   localparam logic [7:0] MSK_POWER_DOWN    = 8'h33;
   localparam logic [7:0] MSK_CLOCK_GATE    = 8'h0b;
   localparam logic [7:0] MSK_IRQ_ENABLE    = 8'h3f;
   localparam logic [7:0] MSK_FSC_LOW       = 8'hff;
   localparam logic [7:0] MSK_FSC_HIGH      = 8'h83;
   localparam logic [7:0] MSK_OUTPUT_MODE   = 8'h03;

   // ==========================================================================
   // Types
   typedef enum logic [1:0] {
      DACR_MODE_BASEBAND = 2'b00,
      DACR_MODE_RZ       = 2'b01,
      DACR_MODE_MIX      = 2'b10
   } dacr_mode_e;

   typedef struct packed {
      logic             wr;
      logic             rd;
      logic [7:0]       addr;
      logic [7:0]       wdata;
   } dacr_cfg_req_s;

   typedef struct packed {
      logic             sdio_out_dir;
      logic             lsb_first;
      logic             diff_driver_off;
      logic             diff_receiver_off;
      logic             clock_receiver_off;
      logic             converter_bias_off;
      logic             clock_distribution_off;
      logic             receive_ctrl_clock_on;
      logic             phase_ctrl_clock_on;
      logic             converter_sleep;
      logic [9:0]       fullscale_code;
      dacr_mode_e       output_switch_mode;
   } dacr_ctrl_s;

   // Index 2 sync, 1 phase (mu), 0 receiver
   typedef struct packed {
      logic             sync_locked;
      logic             phase_locked;
      logic             receiver_locked;
   } dacr_lock_s;

   typedef struct packed {
      logic             early_window;
      logic             late_window;
      logic             sync_quarter;
      logic             sync_zero;
   } dacr_phase_s;

endpackage

/* File: src/dacr_sync3.sv */
/*
   Three-stage synchroniser for levels arriving from outside the register clock.
   The output changes only once the second and third stages agree.
   Assumes inputs are quasi-static levels, not pulses shorter than a few cycles.
*/
module dacr_sync3 #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   // ==========================================================================
   // Stages
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);

   initial begin
      if (WIDTH < 1) $error("dacr_sync3: WIDTH must be at least 1");
   end

   // Stage 1 feeds stage 2 only, to keep metastability contained
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stage1   <= INIT;
         stage2   <= INIT;
         stage3   <= INIT;
         sync_out <= INIT;
      end else begin
         stage1   <= async_in;
         stage2   <= stage1;
         stage3   <= stage2;
         sync_out <= (agree & stage3) | (~agree & sync_out);
      end
   end

endmodule

/* File: src/dacr_lock_flag.sv */
/*
   Locked and lost status pair of one lock controller.
   Assumes the locked level is already synchronised to sys_clk.
*/
module dacr_lock_flag (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic soft_clr,
   input  wire logic locked,
   input  wire logic lock_en,
   input  wire logic lost_en,
   output logic      locked_flag,
   output logic      lost_flag
);

   // ==========================================================================
   // Edge detection and flag update
   logic locked_d;
   wire  lock_dropped = locked_d & ~locked;

   // Locked tracks the level; lost is sticky until its enable drops
   always_ff @(posedge sys_clk) begin
      if (!rst_n || soft_clr) begin
         locked_d    <= 1'b0;
         locked_flag <= 1'b0;
         lost_flag   <= 1'b0;
      end else begin
         locked_d    <= locked;
         locked_flag <= lock_en & locked;
         lost_flag   <= lost_en & (lost_flag | lock_dropped);
      end
   end

endmodule

/* File: verif/dacr_props.sv */
/*
   Port checker of the converter register bank.
   Assumes it is bound to dacr_regs and sees only that module's ports.
*/
module dacr_props
   import dacr_pkg::*;
#(
   parameter int unsigned N_CTRL = 3
) (
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   input  wire dacr_pkg::dacr_cfg_req_s cfg_req,
   input  wire dacr_pkg::dacr_ctrl_s    ctrl,
   input  wire logic [7:0]              cfg_rdata,
   input  wire logic                    cfg_rvalid,
   input  wire dacr_pkg::dacr_lock_s    lock_in,
   input  wire dacr_pkg::dacr_phase_s   phase_in
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire logic [7:0] wd = cfg_req.wdata;

   // ==========================================================
   // Access steps; written fields reach ctrl two edges later
   sequence s_wr(logic [7:0] a);
      cfg_req.wr && cfg_req.addr == a;
   endsequence
   sequence s_rd(logic [7:0] a);
      cfg_req.rd && cfg_req.addr == a;
   endsequence

   // ==========================================================
   // Control outputs follow their writes
   AST_POWER_DOWN: assert property (s_wr(OFS_POWER_DOWN) |-> ##2
      {ctrl.diff_driver_off, ctrl.diff_receiver_off, ctrl.clock_receiver_off,
       ctrl.converter_bias_off} == $past({wd[5:4], wd[1:0]}, 2)) else $error("power-down bad");
   AST_CLOCK_GATE: assert property (s_wr(OFS_CLOCK_GATE) |-> ##2
      {ctrl.clock_distribution_off, ctrl.receive_ctrl_clock_on, ctrl.phase_ctrl_clock_on}
      == $past({wd[3], wd[1:0]}, 2)) else $error("clock gate bad");
   AST_FSC_HIGH: assert property (s_wr(OFS_FSC_HIGH) |-> ##2
      {ctrl.converter_sleep, ctrl.fullscale_code[9:8]} == $past({wd[7], wd[1:0]}, 2))
      else $error("full-scale high bad");
   AST_MODE: assert property (cfg_req.wr && cfg_req.addr == OFS_OUTPUT_MODE &&
      wd[1:0] != 2'h3 |-> ##2 ctrl.output_switch_mode == $past(wd[1:0], 2)) else $error("mode bad");
   AST_SOFT_RESET: assert property (s_wr(OFS_PORT_CONFIG) ##0 wd[5] |-> ##2
      ctrl.fullscale_code == 10'h200 && ctrl.receive_ctrl_clock_on && !ctrl.lsb_first)
      else $error("soft reset bad");
   // Reads answer one edge later; settled levels only
   AST_ZERO_READ: assert property (cfg_req.rd && (cfg_req.addr == OFS_IRQ_ENABLE ||
      cfg_req.addr == 8'h05) |=> cfg_rvalid && cfg_rdata == 8'h00) else $error("nonzero read");
   AST_DCLK_PHASE: assert property ($stable(phase_in)[*6] ##0 s_rd(OFS_DCLK_PHASE) |=>
      cfg_rdata == {5'h00, $past(phase_in.early_window), 1'b0, $past(phase_in.late_window)})
      else $error("data clock phase bad");
   AST_SYNC_PHASE: assert property ($stable(phase_in)[*6] ##0 s_rd(OFS_SYNC_PHASE) |=>
      cfg_rdata == {2'h0, $past(phase_in.sync_quarter), $past(phase_in.sync_zero), 4'h0})
      else $error("sync phase bad");
   AST_LOCK: assert property ((!lock_in.receiver_locked)[*6] ##0 s_rd(OFS_IRQ_STATUS) |=>
      !cfg_rdata[0]) else $error("locked flag without lock");
endmodule

bind dacr_regs dacr_props #(.N_CTRL(N_CTRL)) u_props (.sys_clk(sys_clk), .rst_n(rst_n),
   .cfg_req(cfg_req), .ctrl(ctrl), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
   .lock_in(lock_in), .phase_in(phase_in));

/* File: verif/dacr_regs_tb_top.sv */
/*
   Self-checking bench of the converter register bank.
   Assumes the checker binds itself; inputs change on falling edges.
*/
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module dacr_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import dacr_pkg::*;
   logic          sys_clk    = 1'b0;
   logic          rst_n      = 1'b0;
   dacr_cfg_req_s cfg_req    = '0;
   dacr_ctrl_s    ctrl;
   logic [7:0]    cfg_rdata;
   logic          cfg_rvalid;
   dacr_lock_s    lock_in    = '0;
   dacr_phase_s   phase_in   = '0;
   int            fail_count = 0;
   int            checks     = 0;
   logic [7:0]    exp_q[$];
   logic [7:0]    want;
   logic [7:0]    mdl[9];
   // Readable bits and defaults; write-only and status places read zero
   logic [7:0]    msk[9] = '{8'hc0, 8'h33, 8'h0b, 0, 0, 0, 8'hff, 8'h83, 8'h03};
   logic [7:0]    dft[9] = '{8'h00, 8'h00, 8'h03, 0, 0, 0, 8'h00, 8'h02, 8'h00};

   dacr_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_req(cfg_req), .ctrl(ctrl),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .lock_in(lock_in), .phase_in(phase_in));

   initial forever #25 sys_clk = ~sys_clk;

   // ==========================================================
   // One-cycle strobes; reads note their expectation
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      cfg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge sys_clk);
      cfg_req.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      cfg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      exp_q.push_back(e);
      @(negedge sys_clk);
      cfg_req.rd = 1'b0;
   endtask
   task automatic chk_ctrl();
      logic [21:0] e;
      e = {mdl[0][7:6], mdl[1][5:4], mdl[1][1:0], mdl[2][3], mdl[2][1:0], mdl[7][7],
           mdl[7][1:0], mdl[6], mdl[8][1:0]};
      `CHK(ctrl, e)
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Read data is sampled mid-cycle, where the one-cycle valid is settled
   always @(negedge sys_clk) begin
      if (cfg_rvalid === 1'b1) begin
         want = exp_q.pop_front();
         `CHK(cfg_rdata, want)
      end
   end

   // A hang counts as a mismatch
   initial begin
      repeat (3000) @(posedge sys_clk);
      fail_count++;
      $display("unexpected at %0t: watchdog", $time);
      conclude();
   end

   // ==========================================================
   // Test sequence
   initial begin
      logic [7:0] a;
      logic [7:0] d;
      void'($urandom(22));
      repeat (4) @(negedge sys_clk);
      rst_n = 1'b1;
      mdl = dft;
      for (int i = 0; i < 9; i++) rd(i[7:0], dft[i]);
      $display("test defaults done");
      for (int i = 0; i < 40; i++) begin
         a = 8'($urandom_range(8));
         d = 8'($urandom);
         if (a == 8'h00) d[5] = 1'b0;
         wr(a, d);
         if (!(a == 8'h08 && d[1:0] == 2'h3)) mdl[a] = d & msk[a];
         rd(a, mdl[a]);
      end
      for (int m = 0; m < 4; m++) begin
         wr(8'h08, 8'(m));
         if (m < 3) mdl[8] = 8'(m);
         rd(8'h08, mdl[8]);
      end
      repeat (3) @(negedge sys_clk);
      chk_ctrl();
      $display("test access done");
      wr(8'h03, 8'h3f);
      lock_in = 3'h7;
      repeat (8) @(negedge sys_clk);
      rd(8'h04, 8'h15);
      lock_in = 3'h0;
      repeat (8) @(negedge sys_clk);
      rd(8'h04, 8'h2a);
      wr(8'h03, 8'h00);
      rd(8'h04, 8'h00);
      wr(8'h03, 8'h3f);
      lock_in = 3'h2;
      repeat (8) @(negedge sys_clk);
      rd(8'h04, 8'h04);
      $display("test lock done");
      for (int i = 0; i < 6; i++) begin
         phase_in = 4'($urandom);
         wr(8'h0c, 8'hff);
         repeat (6) @(negedge sys_clk);
         rd(8'h0c, {5'h00, phase_in.early_window, 1'b0, phase_in.late_window});
         rd(8'h0d, {2'h0, phase_in.sync_quarter, phase_in.sync_zero, 4'h0});
      end
      $display("test phase done");
      // Phase views are live levels, not registers: quiet them, though the reads below cover offsets 0 to 8 and skip the phase views
      phase_in = '0;
      wr(8'h00, 8'h20);
      mdl = dft;
      for (int i = 0; i < 9; i++) rd(i[7:0], dft[i]);
      repeat (4) @(negedge sys_clk);
      chk_ctrl();
      `CHK(exp_q.size(), 0)
      $display("test soft reset done");
      conclude();
   end
endmodule
